// >>> src/scd_params.svh
/*
  constants of the spi command decoder: command words, field positions,
  frame word counts, response codes and timing.
  assumes inclusion by the package, the decoder module and the testbench.
*/
//
// Functional notes
// - all-zero command is a no-op; next frame carries the four conversion words
// - a no-op executes only when its command crc passes; error shown next frame
// - reset command word pulses a full reset of all user registers
// - reset latches on last falling clock of output crc word; shorter frame ignores
// - conversion-ready pin drops low the moment a latched reset takes effect
// - any command not executed becomes a no-op; outcome reported next frame
// - lock command sets locked flag; then only no-op, read and unlock accepted
// - unlock command clears the locked flag
// - write command: 011, 8-bit start address, two zeros, count minus one
// - a failed command crc or data crc blocks every register update
// - writes of more than three registers lengthen the frame past six words
// - read command: 101, 8-bit start address, 5-bit count minus one
// - next frame returns registers ascending instead of conversion data
// - frame after a read must carry a no-op; other commands are refused
// - readback word is 16-bit value then 8-bit address, msb aligned
// - invalid readback address returns zero value and zero address
// - when enabled, per-frame clock count mismatch sets fault flag next frame
// - expected clocks: larger word count times word length 24 or 32
// - short frame: lock, unlock, read run after command crc; write after data crc
// - ready pin rises after last conversion word is fully clocked out, or when the acquisition wait after a reset ends
// - standard frame holds six words on each line
// - crc failure executes nothing and sets input crc fault flag
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH
`define SCD_CMD_NULL    16'h0000
`define SCD_CMD_RESET   16'h0011
`define SCD_CMD_LOCK    16'h0555
`define SCD_CMD_UNLOCK  16'h0655
`define SCD_OP_WRITE_REGISTERS_CMD     3'b011
`define SCD_OP_READ_REGISTERS_CMD     3'b101
`define SCD_OP_HI       15
`define SCD_OP_LO       13
`define SCD_ADDR_HI     12
`define SCD_ADDR_LO     5
`define SCD_WZERO_HI    4
`define SCD_WZERO_LO    3
`define SCD_WCNT_HI     2
`define SCD_RCNT_HI     4
`define SCD_WR_MAX      8
`define SCD_STD_WORDS   8'h06
`define SCD_STD_LAST    8'h05
`define SCD_CONV_LAST   8'h04
`define SCD_CRC_IDX     8'h01
`define SCD_WL_SHORT    6'h18
`define SCD_WL_LONG     6'h20
`define SCD_RSP_NULL    4'h0
`define SCD_RSP_RESET   4'h1
`define SCD_RSP_LOCK    4'h2
`define SCD_RSP_UNLOCK  4'h3
`define SCD_RSP_WRITE_REGISTERS_CMD    4'h4
`define SCD_RSP_READ_REGISTERS_CMD    4'h5
`define SCD_RSP_FIRST   4'hf
`define SCD_CLK_NS      5
`define SCD_REGACQ_NS   5000
`define SCD_REGACQ_CYC  ((`SCD_REGACQ_NS + `SCD_CLK_NS - 1) / `SCD_CLK_NS)
`endif

// >>> src/scd_pkg.sv
/*
  types of the spi command decoder: frame phase and command response.
  assumes scd_params.svh on the include path.
*/
`default_nettype none
`include "scd_params.svh"
package scd_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CMD  = 2'b01,
    PH_BODY = 2'b11
  } scd_phase_t;

  typedef enum logic [3:0] {
    RSP_NULL   = `SCD_RSP_NULL,
    RSP_RESET  = `SCD_RSP_RESET,
    RSP_LOCK   = `SCD_RSP_LOCK,
    RSP_UNLOCK = `SCD_RSP_UNLOCK,
    RSP_WRITE_REGISTERS_CMD   = `SCD_RSP_WRITE_REGISTERS_CMD,
    RSP_READ_REGISTERS_CMD   = `SCD_RSP_READ_REGISTERS_CMD,
    RSP_FIRST  = `SCD_RSP_FIRST
  } scd_rsp_t;
endpackage
`default_nettype wire

// >>> src/scd_top.sv
/*
  spi command decoder with serial clock counter, slave side of a full
  duplex frame link: decodes commands, gates them by crc and lock, drives
  status, conversion or readback words, and the conversion-ready pin.
  assumes spi mode with sdo changed on sclk rise and sdi sampled on sclk
  fall, sclk at least 8x slower than i_clk, and an outside crc engine
  and register file on i_clk.
*/
// Chosen here: strobed register access and the register offsets.
`default_nettype none
`include "scd_params.svh"
module scd_top #(
  parameter int P_REGACQ_CYC = `SCD_REGACQ_CYC
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_sclk,
  input  wire logic             i_cs_n,
  input  wire logic             i_sdi,
  input  wire logic             i_word_len32,
  input  wire logic             i_clk_count_en,
  input  wire logic             i_cmd_crc_ok,
  input  wire logic             i_data_crc_ok,
  input  wire logic [15:0]      i_out_crc,
  input  wire logic [95:0]      i_conv_data,
  input  wire logic             i_conv_new,
  input  wire logic [15:0]      i_status_low,
  input  wire logic [15:0]      i_reg_rdata,
  input  wire logic             i_reg_addr_ok,
  input  wire logic             i_reset_flag_clr,
  output logic                  o_sdo,
  output logic                  o_sdo_oe,
  output logic                  o_conversion_ready_pin_n,
  output logic                  o_reg_wr,
  output logic                  o_reg_rd,
  output logic [7:0]            o_reg_addr,
  output logic [15:0]           o_reg_wdata,
  output logic                  o_user_reset,
  output logic                  o_locked,
  output logic                  o_reset_occurred,
  output logic                  o_input_crc_fault,
  output logic                  o_clock_count_fault,
  output scd_pkg::scd_rsp_t     o_cmd_response
);
  import scd_pkg::*;

  localparam int WR_MAX = `SCD_WR_MAX;

  function automatic scd_rsp_t scd_decode(input logic [15:0] w);
    if (w == `SCD_CMD_RESET) return RSP_RESET;
    if (w == `SCD_CMD_LOCK) return RSP_LOCK;
    if (w == `SCD_CMD_UNLOCK) return RSP_UNLOCK;
    if (w[`SCD_OP_HI:`SCD_OP_LO] == `SCD_OP_WRITE_REGISTERS_CMD && w[`SCD_WZERO_HI:`SCD_WZERO_LO] == 2'b00)
      return RSP_WRITE_REGISTERS_CMD;
    if (w[`SCD_OP_HI:`SCD_OP_LO] == `SCD_OP_READ_REGISTERS_CMD) return RSP_READ_REGISTERS_CMD;
    return RSP_NULL;
  endfunction

  function automatic logic [23:0] scd_conv(input logic [95:0] d, input logic [1:0] k);
    logic [23:0] r;
    r = 24'h000000;
    unique case (k)
      2'h0: r = d[95:72];
      2'h1: r = d[71:48];
      2'h2: r = d[47:24];
      2'h3: r = d[23:0];
    endcase
    return r;
  endfunction

  // link inputs cross into i_clk through two flops before any logic
  logic [2:0]  sclk_s;
  logic [2:0]  cs_s;
  logic [1:0]  sdi_s;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_s <= 3'h0;
      cs_s   <= 3'h7;
      sdi_s  <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], i_sclk};
      cs_s   <= {cs_s[1:0], i_cs_n};
      sdi_s  <= {sdi_s[0], i_sdi};
    end
  end

  logic in_frame;
  logic cs_fall;
  logic cs_rise;
  logic s_rise;
  logic s_fall;
  assign in_frame = ~cs_s[1];
  assign cs_fall  = ~cs_s[1] & cs_s[2];
  assign cs_rise  = cs_s[1] & ~cs_s[2];
  assign s_rise   = in_frame & sclk_s[1] & ~sclk_s[2];
  assign s_fall   = in_frame & ~sclk_s[1] & sclk_s[2];

  scd_phase_t  phase;
  logic [5:0]  wl;
  logic [5:0]  bit_cnt;
  logic [7:0]  word_idx;
  logic [15:0] clk_cnt;
  logic [31:0] rx_sh;
  logic [31:0] next_rx;
  logic [15:0] rx_top;
  logic        word_end;

  assign next_rx  = {rx_sh[30:0], sdi_s[1]};
  assign rx_top   = (wl == `SCD_WL_LONG) ? next_rx[31:16] : next_rx[23:8];
  assign word_end = s_fall & (bit_cnt == wl - 6'h01);

  // bit and word position, pulse count
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wl       <= `SCD_WL_SHORT;
      bit_cnt  <= 6'h00;
      word_idx <= 8'h00;
      clk_cnt  <= 16'h0000;
      rx_sh    <= 32'h00000000;
    end else if (cs_fall) begin
      wl       <= i_word_len32 ? `SCD_WL_LONG : `SCD_WL_SHORT;
      bit_cnt  <= 6'h00;
      word_idx <= 8'h00;
      clk_cnt  <= 16'h0000;
    end else if (s_fall) begin
      rx_sh    <= next_rx;
      // saturate so a runaway clock still reads as a mismatch
      if (clk_cnt != 16'hffff) clk_cnt <= clk_cnt + 16'h0001;
      if (word_end) begin
        bit_cnt <= 6'h00;
        if (word_idx != 8'hff) word_idx <= word_idx + 8'h01;
      end else begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  logic crc_end;
  assign crc_end = word_end & (word_idx == `SCD_CRC_IDX) & (phase == PH_CMD);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      phase <= PH_IDLE;
    end else begin
      unique case (phase)
        PH_IDLE: if (cs_fall) phase <= PH_CMD;
        PH_CMD:  if (cs_rise) phase <= PH_IDLE;
                 else if (crc_end) phase <= PH_BODY;
        PH_BODY: if (cs_rise) phase <= PH_IDLE;
        default: phase <= PH_IDLE;
      endcase
    end
  end

  // command decode and execution
  logic [15:0] cmd_word;
  scd_rsp_t    kind;
  logic        cmd_ok;
  logic        rb_frame;
  logic        rd_pend;
  logic [7:0]  rd_base;
  logic [4:0]  rd_n;
  logic [7:0]  rb_base;
  logic [4:0]  rb_n;
  logic [7:0]  out_last;
  logic [7:0]  exp_words;
  logic [7:0]  in_words;
  logic [7:0]  out_words;
  logic        wr_arm;
  logic [7:0]  wr_base;
  logic [2:0]  wr_n;
  logic        rst_arm;
  logic        rst_hit;
  logic        wr_start;
  scd_rsp_t    exec_rsp;
  logic        crc_fault_cur;
  logic        locked;
  logic        data_end;

  assign kind = scd_decode(cmd_word);
  // refused in a readback frame or while locked, except the accepted set
  assign cmd_ok = i_cmd_crc_ok & ((kind == RSP_NULL) | (~rb_frame & (~locked
                  | kind == RSP_READ_REGISTERS_CMD | kind == RSP_UNLOCK)));
  assign in_words  = (kind == RSP_WRITE_REGISTERS_CMD) ? 8'(cmd_word[`SCD_WCNT_HI:0]) + 8'h04 : `SCD_STD_WORDS;
  assign out_words = out_last + 8'h01;
  assign data_end  = word_end & wr_arm & (phase == PH_BODY) & (word_idx == 8'(wr_n) + 8'h03);
  assign rst_hit   = word_end & rst_arm & (word_idx == out_last);
  assign wr_start  = data_end & i_data_crc_ok;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cmd_word      <= `SCD_CMD_NULL;
      rb_frame      <= 1'b0;
      rd_pend       <= 1'b0;
      rd_base       <= 8'h00;
      rd_n          <= 5'h00;
      rb_base       <= 8'h00;
      rb_n          <= 5'h00;
      out_last      <= `SCD_STD_LAST;
      exp_words     <= `SCD_STD_WORDS;
      wr_arm        <= 1'b0;
      wr_base       <= 8'h00;
      wr_n          <= 3'h0;
      rst_arm       <= 1'b0;
      exec_rsp      <= RSP_FIRST;
      crc_fault_cur <= 1'b0;
      locked        <= 1'b0;
    end else if (rst_hit) begin
      rd_pend       <= 1'b0;
      rst_arm       <= 1'b0;
      wr_arm        <= 1'b0;
      locked        <= 1'b0;
      exec_rsp      <= RSP_FIRST;
    end else if (cs_fall) begin
      cmd_word      <= `SCD_CMD_NULL;
      rb_frame      <= rd_pend;
      rb_base       <= rd_base;
      rb_n          <= rd_n;
      rd_pend       <= 1'b0;
      out_last      <= rd_pend ? 8'(rd_n) + 8'h02 : `SCD_STD_LAST;
      exp_words     <= rd_pend ? 8'(rd_n) + 8'h03 : `SCD_STD_WORDS;
      wr_arm        <= 1'b0;
      rst_arm       <= 1'b0;
      exec_rsp      <= RSP_NULL;
      crc_fault_cur <= 1'b0;
    end else if (word_end & (word_idx == 8'h00) & (phase == PH_CMD)) begin
      cmd_word      <= rx_top;
    end else if (crc_end) begin
      // larger of input and output length decides the clock budget
      exp_words     <= (in_words > out_words) ? in_words : out_words;
      if (!i_cmd_crc_ok) crc_fault_cur <= 1'b1;
      if (cmd_ok) begin
        unique case (kind)
          RSP_LOCK:   begin locked <= 1'b1; exec_rsp <= RSP_LOCK; end
          RSP_UNLOCK: begin locked <= 1'b0; exec_rsp <= RSP_UNLOCK; end
          RSP_READ_REGISTERS_CMD: begin
            rd_pend  <= 1'b1;
            rd_base  <= cmd_word[`SCD_ADDR_HI:`SCD_ADDR_LO];
            rd_n     <= cmd_word[`SCD_RCNT_HI:0];
            exec_rsp <= RSP_READ_REGISTERS_CMD;
          end
          RSP_WRITE_REGISTERS_CMD: begin
            wr_arm   <= 1'b1;
            wr_base  <= cmd_word[`SCD_ADDR_HI:`SCD_ADDR_LO];
            wr_n     <= cmd_word[`SCD_WCNT_HI:0];
          end
          RSP_RESET: rst_arm <= 1'b1;
          default:   exec_rsp <= RSP_NULL;
        endcase
      end
    end else if (data_end) begin
      wr_arm <= 1'b0;
      if (i_data_crc_ok) exec_rsp <= RSP_WRITE_REGISTERS_CMD;
      else crc_fault_cur <= 1'b1;
    end
  end

  // data words are held until their crc passes, so a bad frame writes nothing
  logic [15:0] wr_buf [WR_MAX];
  logic [3:0]  wr_left;
  logic [2:0]  wr_pos;

  always_ff @(posedge i_clk) begin
    if (word_end & wr_arm & (phase == PH_BODY) & (word_idx >= 8'h02)
        & (word_idx <= 8'(wr_n) + 8'h02)) begin
      wr_buf[3'(word_idx - 8'h02)] <= rx_top;
    end
  end

  // register port: burst writes, readback fetches one word ahead
  logic        prep_go;
  logic [7:0]  prep_idx;
  logic [1:0]  prep_d;
  logic [7:0]  prep_k1;
  logic [7:0]  prep_k;
  logic        rb_word;
  assign prep_go  = cs_fall | word_end;
  assign prep_idx = cs_fall ? 8'h00 : word_idx + 8'h01;
  assign rb_word  = rb_frame & (prep_idx != 8'h00) & (prep_idx <= 8'(rb_n) + 8'h01);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_wr    <= 1'b0;
      o_reg_rd    <= 1'b0;
      o_reg_addr  <= 8'h00;
      o_reg_wdata <= 16'h0000;
      wr_left     <= 4'h0;
      wr_pos      <= 3'h0;
    end else if (wr_start) begin
      o_reg_wr    <= 1'b0;
      o_reg_rd    <= 1'b0;
      wr_left     <= 4'(wr_n) + 4'h1;
      wr_pos      <= 3'h0;
    end else if (wr_left != 4'h0) begin
      o_reg_wr    <= 1'b1;
      o_reg_rd    <= 1'b0;
      o_reg_addr  <= wr_base + 8'(wr_pos);
      o_reg_wdata <= wr_buf[wr_pos];
      wr_pos      <= wr_pos + 3'h1;
      wr_left     <= wr_left - 4'h1;
    end else if (prep_go & rb_word & ~rst_hit) begin
      o_reg_wr    <= 1'b0;
      o_reg_rd    <= 1'b1;
      o_reg_addr  <= rb_base + (prep_idx - 8'h01);
    end else begin
      o_reg_wr    <= 1'b0;
      o_reg_rd    <= 1'b0;
    end
  end

  // status flags reported in the following frame
  logic crc_fault_rep;
  logic clk_fault_rep;
  logic [15:0] exp_clk;
  assign exp_clk = 16'(exp_words) * 16'(wl);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      crc_fault_rep  <= 1'b0;
      clk_fault_rep  <= 1'b0;
      o_cmd_response <= RSP_FIRST;
    end else if (cs_rise) begin
      crc_fault_rep  <= crc_fault_cur;
      clk_fault_rep  <= i_clk_count_en & (clk_cnt != exp_clk);
      o_cmd_response <= exec_rsp;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reset_occurred <= 1'b1;
    end else if (rst_hit) begin
      o_reset_occurred <= 1'b1;
    end else if (i_reset_flag_clr) begin
      o_reset_occurred <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_locked            <= 1'b0;
      o_input_crc_fault   <= 1'b0;
      o_clock_count_fault <= 1'b0;
      o_user_reset        <= 1'b0;
    end else begin
      o_locked            <= locked;
      o_input_crc_fault   <= crc_fault_rep;
      o_clock_count_fault <= clk_fault_rep;
      o_user_reset        <= rst_hit;
    end
  end

  // output word assembly; the crc word comes from the outside engine
  logic [31:0] tx_next;
  logic [31:0] tx_sh;
  logic [23:0] status_w;
  assign status_w = {~o_reset_occurred, ~crc_fault_rep, ~clk_fault_rep,
                     o_cmd_response, locked, i_status_low};

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prep_d  <= 2'h0;
      prep_k1 <= 8'h00;
      prep_k  <= 8'h00;
      tx_next <= 32'h00000000;
    end else begin
      // extra stage: read data stand the cycle after the strobe
      prep_d  <= {prep_d[0], prep_go};
      prep_k1 <= prep_idx;
      prep_k  <= prep_k1;
      if (prep_d[1]) begin
        if (prep_k == 8'h00)
          tx_next <= {status_w, 8'h00};
        else if (prep_k == out_last)
          tx_next <= {i_out_crc, 16'h0000};
        else if (rb_frame)
          tx_next <= i_reg_addr_ok ? {i_reg_rdata, o_reg_addr, 8'h00}
                                   : 32'h00000000;
        else if (prep_k <= `SCD_CONV_LAST)
          tx_next <= {scd_conv(i_conv_data, 2'(prep_k - 8'h01)), 8'h00};
        else
          tx_next <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sdo    <= 1'b0;
      o_sdo_oe <= 1'b0;
      tx_sh    <= 32'h00000000;
    end else begin
      o_sdo_oe <= in_frame;
      if (!in_frame) begin
        o_sdo <= 1'b0;
      end else if (s_rise) begin
        if (bit_cnt == 6'h00) begin
          o_sdo <= tx_next[31];
          tx_sh <= {tx_next[30:0], 1'b0};
        end else begin
          o_sdo <= tx_sh[31];
          tx_sh <= {tx_sh[30:0], 1'b0};
        end
      end
    end
  end

  // conversion-ready pin: low on new data or reset, high once all read
  logic [31:0] acq_cnt;
  logic        conv_read;
  assign conv_read = word_end & ~rb_frame & (word_idx == `SCD_CONV_LAST);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_conversion_ready_pin_n <= 1'b0;
      acq_cnt                  <= 32'(P_REGACQ_CYC);
    end else if (rst_hit) begin
      o_conversion_ready_pin_n <= 1'b0;
      acq_cnt                  <= 32'(P_REGACQ_CYC);
    end else if (acq_cnt != 32'h00000000) begin
      acq_cnt <= acq_cnt - 32'h00000001;
      if (acq_cnt == 32'h00000001) o_conversion_ready_pin_n <= 1'b1;
    end else if (i_conv_new) begin
      o_conversion_ready_pin_n <= 1'b0;
    end else if (conv_read) begin
      o_conversion_ready_pin_n <= 1'b1;
    end
  end

endmodule // scd_top
`default_nettype wire

// >>> verification/scd_host_model.sv
/*
  host side of the serial link: frames of words, msb first, 16-bit content on top.
  assumes sdo changes after sclk rise and sdi is taken on sclk fall.
*/
`default_nettype none
module scd_host_model (
  input  wire logic i_sdo,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rx [0:15];
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end
  // word 0 command, word 1 its crc, then data words and data crc
  task automatic frame(input logic [15:0] cmd, input logic [15:0] dat, input int npulse, input int wl);
    int wi;
    int bi;
    logic [15:0] w;
    foreach (rx[i]) rx[i] = 32'h0;
    o_cs_n = 1'b0;
    #100;
    for (int p = 0; p < npulse; p++) begin
      wi = p / wl;
      bi = wl - 1 - (p % wl);
      w = (wi == 0) ? cmd : (wi == 1) ? 16'h0000 : dat + 16'(wi);
      o_sdi = (bi >= wl - 16) ? w[bi - (wl - 16)] : 1'b0;
      o_sclk = 1'b1;
      #32;
      if (wi < 16) rx[wi][bi] = i_sdo;
      o_sclk = 1'b0;
      #32;
    end
    #100;
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;  // idle line must not look like the last bit
    #300;
  endtask
endmodule // scd_host_model
`default_nettype wire

// >>> verification/scd_top_assertions.sv
/*
  port checker of scd_top: command gating, write bursts, reset pulse,
  ready pin and end-of-frame flags.
  assumes it is bound onto scd_top; single i_clk domain.
*/
`default_nettype none
module scd_top_assertions (
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_cs_n,
  input wire logic       i_conv_new,
  input wire logic       i_cmd_crc_ok,
  input wire logic       i_data_crc_ok,
  input wire logic       o_sdo_oe,
  input wire logic       o_conversion_ready_pin_n,
  input wire logic       o_reg_wr,
  input wire logic       o_reg_rd,
  input wire logic [7:0] o_reg_addr,
  input wire logic       o_user_reset,
  input wire logic       o_locked,
  input wire logic       o_reset_occurred,
  input wire logic       o_input_crc_fault,
  input wire logic       o_clock_count_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wr_run;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // length of the current write burst, kept small on purpose
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) wr_run <= 4'h0;
    else wr_run <= o_reg_wr ? wr_run + 4'h1 : 4'h0;
  end
  AST_WR_UNLOCKED: assert property (o_reg_wr |-> !o_locked) else $error("write while locked");
  AST_WR_CRC_OK: assert property (o_reg_wr |-> (i_cmd_crc_ok && i_data_crc_ok))
    else $error("write despite crc failure");
  AST_WR_ASCENDING: assert property ((o_reg_wr && $past(o_reg_wr)) |->
    (o_reg_addr == $past(o_reg_addr) + 8'h01)) else $error("write burst not ascending");
  AST_WR_RUN_MAX: assert property (o_reg_wr |-> (wr_run < 4'h8)) else $error("write burst too long");
  AST_RD_IN_FRAME: assert property (o_reg_rd |-> o_sdo_oe) else $error("read outside frame");
  AST_NEW_CONV_LOW: assert property (i_conv_new |-> ##[1:2] !o_conversion_ready_pin_n)
    else $error("ready pin not low on new data");
  AST_USER_RST_ONE: assert property (o_user_reset |=> !o_user_reset) else $error("reset pulse too long");
  AST_RST_READY_LOW: assert property (o_user_reset |-> ##[0:1] !o_conversion_ready_pin_n)
    else $error("ready pin high at reset");
  AST_RST_FLAG: assert property (o_user_reset |-> ##[0:3] o_reset_occurred) else $error("reset flag not set");
  AST_LOCK_IN_FRAME: assert property ($changed(o_locked) |-> o_sdo_oe) else $error("lock moved idle");
  AST_CLKF_AT_END: assert property ($changed(o_clock_count_fault) |-> i_cs_n)
    else $error("clock fault moved mid frame");
  AST_CRCF_AT_END: assert property ($changed(o_input_crc_fault) |-> i_cs_n)
    else $error("crc fault moved mid frame");
  COV_WRITE: cover property (o_reg_wr ##1 o_reg_wr);
  COV_READ: cover property (o_reg_rd);
  COV_RESET: cover property (o_user_reset);
  COV_LOCK: cover property ($rose(o_locked));
endmodule // scd_top_assertions
bind scd_top scd_top_assertions chk_u (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cs_n(i_cs_n), .i_conv_new(i_conv_new),
  .i_cmd_crc_ok(i_cmd_crc_ok), .i_data_crc_ok(i_data_crc_ok), .o_sdo_oe(o_sdo_oe),
  .o_conversion_ready_pin_n(o_conversion_ready_pin_n), .o_reg_wr(o_reg_wr), .o_reg_rd(o_reg_rd),
  .o_reg_addr(o_reg_addr), .o_user_reset(o_user_reset), .o_locked(o_locked),
  .o_reset_occurred(o_reset_occurred), .o_input_crc_fault(o_input_crc_fault),
  .o_clock_count_fault(o_clock_count_fault));
`default_nettype wire

// >>> verification/scd_top_tb.sv
/*
  testbench of scd_top: command frames through the host model, register port answers.
  assumes scd_pkg, scd_params.svh and the host model are compiled first.
*/
`default_nettype none
`include "scd_params.svh"
module scd_top_tb;
  import scd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          ACQ  = 20;
  localparam logic [95:0] CONV = 96'h8a1b2c_4d5e6f_0718a9_b3c4d5;
  logic        i_clk, i_sys_rst, i_sclk, i_cs_n, i_sdi, i_word_len32, i_clk_count_en;
  logic        i_cmd_crc_ok, i_data_crc_ok, i_conv_new, i_reg_addr_ok, i_reset_flag_clr;
  logic [15:0] i_reg_rdata, o_reg_wdata;
  logic        o_sdo, o_sdo_oe, o_rdy_n, o_reg_wr, o_reg_rd, o_user_reset, o_locked;
  logic        o_reset_occurred, o_input_crc_fault, o_clock_count_fault;
  logic [7:0]  o_reg_addr;
  scd_rsp_t    o_cmd_response;
  int          mismatches, n_compared, n_wr, n_rd, n_rst, wl, s;
  scd_top #(.P_REGACQ_CYC(ACQ)) dut_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_sdi(i_sdi),
    .i_word_len32(i_word_len32), .i_clk_count_en(i_clk_count_en), .i_cmd_crc_ok(i_cmd_crc_ok),
    .i_data_crc_ok(i_data_crc_ok), .i_out_crc(16'hc3a5), .i_conv_data(CONV), .i_conv_new(i_conv_new),
    .i_status_low(16'h3c5a), .i_reg_rdata(i_reg_rdata), .i_reg_addr_ok(i_reg_addr_ok),
    .i_reset_flag_clr(i_reset_flag_clr), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .o_conversion_ready_pin_n(o_rdy_n), .o_reg_wr(o_reg_wr), .o_reg_rd(o_reg_rd),
    .o_reg_addr(o_reg_addr), .o_reg_wdata(o_reg_wdata), .o_user_reset(o_user_reset),
    .o_locked(o_locked), .o_reset_occurred(o_reset_occurred), .o_input_crc_fault(o_input_crc_fault),
    .o_clock_count_fault(o_clock_count_fault), .o_cmd_response(o_cmd_response));
  scd_host_model host_u (.i_sdo(o_sdo), .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdi(i_sdi));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // register file stand-in: answer one cycle after the read strobe, 11h unmapped
  always @(posedge i_clk) begin
    if (o_reg_wr === 1'b1) n_wr++;
    if (o_reg_rd === 1'b1) n_rd++;
    if (o_user_reset === 1'b1) n_rst++;
    i_reg_rdata <= {o_reg_addr, 8'ha5};
    i_reg_addr_ok <= (o_reg_addr != 8'h11);
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic fr(input logic [15:0] cmd, input logic [15:0] dat, input int np, input logic [3:0] rsp);
    host_u.frame(cmd, dat, np, wl);
    repeat (4) @(posedge i_clk);
    chk(32'(o_cmd_response), 32'(rsp));
  endtask
  task automatic pulse_conv;
    i_conv_new <= 1'b1;
    @(posedge i_clk);
    i_conv_new <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 200 && o_rdy_n !== 1'b1; i++) @(posedge i_clk);
    chk(o_rdy_n, 1);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    close_out();
  end
  initial begin
    {i_sys_rst, i_word_len32, i_clk_count_en, i_cmd_crc_ok, i_data_crc_ok} = 5'b10111;
    {i_conv_new, i_reset_flag_clr} = '0;
    wl = 24;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    chk(o_reset_occurred, 1);
    wait_ready();
    pulse_conv();
    chk(o_rdy_n, 0);
    fr(`SCD_CMD_NULL, 0, 6 * wl, RSP_NULL);
    for (int i = 1; i < 5; i++) chk(host_u.rx[i][23:0], CONV[119 - 24 * i -: 24]);
    chk(host_u.rx[0][23:0], {8'h7e, 16'h3c5a});
    chk(host_u.rx[5][23:8], 16'hc3a5);
    chk(o_rdy_n, 1);
    i_reset_flag_clr <= 1'b1;
    @(posedge i_clk);
    i_reset_flag_clr <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk(o_reset_occurred, 0);
    pulse_conv();
    i_cmd_crc_ok <= 1'b0;
    fr(`SCD_CMD_NULL, 0, 3 * wl, RSP_NULL);
    chk(o_rdy_n, 0);
    chk({o_clock_count_fault, o_input_crc_fault}, 2'b11);
    i_cmd_crc_ok <= 1'b1;
    fr(`SCD_CMD_NULL, 0, 6 * wl, RSP_NULL);
    chk(host_u.rx[0][22], 0);
    chk({o_clock_count_fault, o_input_crc_fault, o_rdy_n}, 3'b001);
    for (int k = 0; k < 3; k++) begin
      i_word_len32 <= (k != 0);
      wl = (k == 0) ? 24 : 32;
      fr(`SCD_CMD_NULL, 0, (k == 0) ? 145 : (k == 1) ? 192 : 144, RSP_NULL);
      chk(o_clock_count_fault, k != 1);
    end
    i_word_len32 <= 1'b0;
    wl = 24;
    fr(`SCD_CMD_LOCK, 0, 6 * wl, RSP_LOCK);
    chk(o_locked, 1);
    s = n_wr;
    fr({`SCD_OP_WRITE_REGISTERS_CMD, 8'h20, 2'b00, 3'd0}, 16'h1100, 6 * wl, RSP_NULL);
    chk(n_wr - s, 0);
    fr({`SCD_OP_READ_REGISTERS_CMD, 8'h10, 5'd1}, 0, 6 * wl, RSP_READ_REGISTERS_CMD);
    s = n_rd;
    fr(`SCD_CMD_NULL, 0, 6 * wl, RSP_NULL);
    chk(n_rd - s, 2);
    chk(host_u.rx[1][23:0], {8'h10, 8'ha5, 8'h10});
    chk(host_u.rx[2][23:0], 24'h0);
    fr(`SCD_CMD_UNLOCK, 0, 6 * wl, RSP_UNLOCK);
    chk(o_locked, 0);
    fr({`SCD_OP_READ_REGISTERS_CMD, 8'h10, 5'd0}, 0, 6 * wl, RSP_READ_REGISTERS_CMD);
    fr(`SCD_CMD_LOCK, 0, 6 * wl, RSP_NULL);
    chk(o_locked, 0);
    s = n_wr;
    fr({`SCD_OP_WRITE_REGISTERS_CMD, 8'h20, 2'b00, 3'd3}, 16'h4000, 7 * wl, RSP_WRITE_REGISTERS_CMD);
    chk({n_wr - s, o_reg_addr, o_reg_wdata}, {32'd4, 8'h23, 16'h4005});
    chk(o_clock_count_fault, 0);
    fr({`SCD_OP_WRITE_REGISTERS_CMD, 8'h31, 2'b00, 3'd0}, 16'h5000, 4 * wl, RSP_WRITE_REGISTERS_CMD);
    chk({n_wr - s, o_reg_addr, o_reg_wdata}, {32'd5, 8'h31, 16'h5002});
    fr(`SCD_CMD_LOCK, 0, 2 * wl, RSP_LOCK);
    chk(o_locked, 1);
    fr(`SCD_CMD_UNLOCK, 0, 6 * wl, RSP_UNLOCK);
    for (int k = 0; k < 2; k++) begin
      {i_cmd_crc_ok, i_data_crc_ok} <= k ? 2'b10 : 2'b01;
      s = n_wr;
      fr({`SCD_OP_WRITE_REGISTERS_CMD, 8'h20, 2'b00, 3'd0}, 16'h7700, 6 * wl, RSP_NULL);
      chk({n_wr - s, o_input_crc_fault}, {32'd0, 1'b1});
    end
    {i_cmd_crc_ok, i_data_crc_ok} <= 2'b11;
    fr(16'h1234, 0, 6 * wl, RSP_NULL);
    chk(o_locked, 0);
    s = n_rst;
    fr(`SCD_CMD_RESET, 0, 5 * wl, RSP_NULL);
    chk(n_rst - s, 0);
    host_u.frame(`SCD_CMD_RESET, 0, 6 * wl, wl);
    chk({n_rst - s, o_reset_occurred}, {32'd1, 1'b1});
    wait_ready();
    close_out();
  end
endmodule // scd_top_tb
`default_nettype wire
